// ---- hdl/spm_monitor.sv ----
// Per-path near-end performance monitor for high-order STS / VC-4 paths.
// Assumes framer and pointer processor event inputs are on i_ref_clk.
`timescale 1ns/1ns
module spm_monitor #(
	parameter int NUM_PATHS = 4,
	parameter int CNT_W = 16,
	parameter int SEC_CYCLES = spm_pkg::SEC_CYCLES_DFLT
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [NUM_PATHS-1:0] i_monitor_enable,
	input wire logic [NUM_PATHS-1:0] i_ccat_tail,
	input wire logic i_just_mon_enable,
	input wire logic [spm_pkg::SEC_W-1:0] i_tca_cv_thresh,
	input wire logic [NUM_PATHS-1:0] i_frame_pulse,
	input wire logic [spm_pkg::B3_W*NUM_PATHS-1:0] i_b3_err_cnt,
	input wire logic [NUM_PATHS-1:0] i_ais,
	input wire logic [NUM_PATHS-1:0] i_lop,
	input wire logic [NUM_PATHS-1:0] i_lower_defect,
	input wire logic [NUM_PATHS-1:0] i_uneq,
	input wire logic [NUM_PATHS-1:0] i_tim,
	input wire logic [NUM_PATHS-1:0] i_ptr_valid,
	input wire logic [spm_pkg::PTR_W*NUM_PATHS-1:0] i_ptr_value,
	input wire logic [NUM_PATHS-1:0] i_pj_det_pos,
	input wire logic [NUM_PATHS-1:0] i_pj_det_neg,
	input wire logic [NUM_PATHS-1:0] i_spe_slow,
	input wire logic [NUM_PATHS-1:0] i_spe_fast,
	input wire logic [$clog2(NUM_PATHS)-1:0] i_rd_sel,
	output logic o_sec_tick,
	output logic [NUM_PATHS-1:0] o_gen_pos_just,
	output logic [NUM_PATHS-1:0] o_gen_neg_just,
	output logic [NUM_PATHS-1:0] o_ptr_fault,
	output logic [NUM_PATHS-1:0] o_unavailable,
	output logic [NUM_PATHS-1:0] o_threshold_crossing_alert,
	output logic [CNT_W-1:0] o_path_parity_violation_count,
	output logic [CNT_W-1:0] o_path_errored_seconds,
	output logic [CNT_W-1:0] o_path_severe_errored_seconds,
	output logic [CNT_W-1:0] o_path_unavailable_seconds,
	output logic [CNT_W-1:0] o_path_failure_event_count,
	output logic o_just_valid,
	output logic [CNT_W-1:0] o_pos_just_detected_count,
	output logic [CNT_W-1:0] o_neg_just_detected_count,
	output logic [CNT_W-1:0] o_pos_just_generated_count,
	output logic [CNT_W-1:0] o_neg_just_generated_count,
	output logic [CNT_W:0] o_just_count_difference,
	output logic [CNT_W-1:0] o_detected_just_seconds,
	output logic [CNT_W-1:0] o_generated_just_seconds
);
	import spm_pkg::*;
	// ****************************************************************
	// One-second timebase
	// ****************************************************************
	logic tick;
	spm_sec_timer #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.o_sec_tick(tick)
	);
	// ****************************************************************
	// Per-path second state
	// ****************************************************************
	logic [NUM_PATHS-1:0] men;
	logic [SEC_W-1:0] cv_sec_r [NUM_PATHS];
	logic [SEC_W-1:0] cv_sec_nxt [NUM_PATHS];
	logic [NUM_PATHS-1:0] es_flag_r, es_flag_nxt;
	logic [NUM_PATHS-1:0] sev_flag_r, sev_flag_nxt;
	logic [NUM_PATHS-1:0] pjd_flag_r, pjd_flag_nxt;
	logic [NUM_PATHS-1:0] pjg_flag_r, pjg_flag_nxt;
	logic [NUM_PATHS-1:0] fail_r, fail_nxt;
	logic [NUM_PATHS-1:0] gpos_r, gpos_nxt;
	logic [NUM_PATHS-1:0] gneg_r, gneg_nxt;
	logic [NUM_PATHS-1:0] pfault_r, pfault_nxt;
	logic [NUM_PATHS-1:0] tca_r, tca_nxt;
	logic [RUN_W-1:0] run_r [NUM_PATHS];
	logic [RUN_W-1:0] run_nxt [NUM_PATHS];
	spm_avail_t avail_r [NUM_PATHS];
	spm_avail_t avail_nxt [NUM_PATHS];
	logic ev_en [NUM_PATHS][NK];
	logic [B3_W-1:0] ev_amt [NUM_PATHS][NK];
	logic [CNT_W-1:0] cnt [NUM_PATHS][NK];
	// A non-first constituent of a contiguous group can never be enabled
	assign men = i_monitor_enable & ~i_ccat_tail;
	always_comb
	begin
		logic [B3_W-1:0] b3;
		logic [SEC_W:0] cv_sum;
		logic [SEC_W-1:0] cv_tot;
		logic fail_now;
		logic es_q;
		logic ses_q;
		logic pjd_q;
		logic pjg_q;
		logic [RUN_W-1:0] run_inc;
		b3 = '0;
		cv_sum = '0;
		cv_tot = '0;
		fail_now = 1'b0;
		es_q = 1'b0;
		ses_q = 1'b0;
		pjd_q = 1'b0;
		pjg_q = 1'b0;
		run_inc = '0;
		for (int i = 0; i < NUM_PATHS; i++)
		begin
			b3 = i_b3_err_cnt[B3_W*i +: B3_W];
			if (b3 > B3_MAX_PER_FRAME)
				b3 = B3_MAX_PER_FRAME;
			if (!i_frame_pulse[i])
				b3 = '0;
			cv_sum = {1'b0, cv_sec_r[i]} + (SEC_W+1)'(b3);
			cv_tot = cv_sum[SEC_W] ? '1 : cv_sum[SEC_W-1:0];
			fail_now = i_ais[i] | i_lop[i] | i_uneq[i] | i_tim[i];
			// Events in the tick cycle still belong to the closing second
			es_q = es_flag_r[i] | (b3 != '0) | i_ais[i] | i_lower_defect[i] | i_lop[i];
			ses_q = sev_flag_r[i] | (cv_tot >= SES_CV_THRESH) | i_ais[i] | i_lop[i];
			pjd_q = pjd_flag_r[i] | i_just_mon_enable & (i_pj_det_pos[i] | i_pj_det_neg[i]);
			pjg_q = pjg_flag_r[i] | i_just_mon_enable & (gpos_r[i] | gneg_r[i]);
			run_inc = run_r[i] + RUN_W'(1);
			// Justification generation follows the envelope rate on each frame
			gpos_nxt[i] = i_frame_pulse[i] & i_spe_slow[i];
			gneg_nxt[i] = i_frame_pulse[i] & i_spe_fast[i] & ~i_spe_slow[i];
			pfault_nxt[i] = pfault_r[i];
			if (i_ptr_valid[i])
				pfault_nxt[i] = (i_ptr_value[PTR_W*i +: PTR_W] > PTR_MAX);
			fail_nxt[i] = fail_now & men[i];
			cv_sec_nxt[i] = tick ? '0 : cv_tot;
			es_flag_nxt[i] = tick ? 1'b0 : es_q;
			sev_flag_nxt[i] = tick ? 1'b0 : ses_q;
			pjd_flag_nxt[i] = tick ? 1'b0 : pjd_q;
			pjg_flag_nxt[i] = tick ? 1'b0 : pjg_q;
			run_nxt[i] = run_r[i];
			avail_nxt[i] = avail_r[i];
			tca_nxt[i] = tick & men[i] & (cv_tot >= i_tca_cv_thresh);
			if (tick)
			begin
				case (avail_r[i])
					SPM_AVAIL:
					begin
						run_nxt[i] = ses_q ? run_inc : RUN_RST;
						if (ses_q && run_inc == UAS_RUN)
						begin
							avail_nxt[i] = SPM_UNAVAIL;
							run_nxt[i] = RUN_RST;
						end
					end
					SPM_UNAVAIL:
					begin
						run_nxt[i] = ses_q ? RUN_RST : run_inc;
						if (!ses_q && run_inc == UAS_RUN)
						begin
							avail_nxt[i] = SPM_AVAIL;
							run_nxt[i] = RUN_RST;
						end
					end
					default:
					begin
						avail_nxt[i] = SPM_AVAIL;
						run_nxt[i] = RUN_RST;
					end
				endcase
			end
			// Disabled paths hold no partial second, so enabling starts clean
			if (!men[i])
			begin
				cv_sec_nxt[i] = '0;
				es_flag_nxt[i] = 1'b0;
				sev_flag_nxt[i] = 1'b0;
				pjd_flag_nxt[i] = 1'b0;
				pjg_flag_nxt[i] = 1'b0;
				run_nxt[i] = RUN_RST;
				avail_nxt[i] = SPM_AVAIL;
			end
			for (int k = 0; k < NK; k++)
				ev_amt[i][k] = B3_W'(1);
			ev_amt[i][K_CV] = b3;
			ev_en[i][K_CV] = men[i] & (b3 != '0);
			ev_en[i][K_ES] = men[i] & tick & es_q;
			ev_en[i][K_SES] = men[i] & tick & ses_q;
			ev_en[i][K_UAS] = men[i] & tick & (avail_nxt[i] == SPM_UNAVAIL);
			ev_en[i][K_FC] = men[i] & fail_now & ~fail_r[i];
			ev_en[i][K_PPD] = men[i] & i_just_mon_enable & i_pj_det_pos[i];
			ev_en[i][K_NPD] = men[i] & i_just_mon_enable & i_pj_det_neg[i];
			ev_en[i][K_PPG] = men[i] & i_just_mon_enable & gpos_r[i];
			ev_en[i][K_NPG] = men[i] & i_just_mon_enable & gneg_r[i];
			ev_en[i][K_PJSD] = men[i] & i_just_mon_enable & tick & pjd_q;
			ev_en[i][K_PJSG] = men[i] & i_just_mon_enable & tick & pjg_q;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			es_flag_r <= '0;
			sev_flag_r <= '0;
			pjd_flag_r <= '0;
			pjg_flag_r <= '0;
			fail_r <= '0;
			gpos_r <= '0;
			gneg_r <= '0;
			pfault_r <= '0;
			tca_r <= '0;
			for (int i = 0; i < NUM_PATHS; i++)
			begin
				cv_sec_r[i] <= '0;
				run_r[i] <= RUN_RST;
				avail_r[i] <= SPM_AVAIL;
			end
		end
		else
		begin
			es_flag_r <= es_flag_nxt;
			sev_flag_r <= sev_flag_nxt;
			pjd_flag_r <= pjd_flag_nxt;
			pjg_flag_r <= pjg_flag_nxt;
			fail_r <= fail_nxt;
			gpos_r <= gpos_nxt;
			gneg_r <= gneg_nxt;
			pfault_r <= pfault_nxt;
			tca_r <= tca_nxt;
			for (int i = 0; i < NUM_PATHS; i++)
			begin
				cv_sec_r[i] <= cv_sec_nxt[i];
				run_r[i] <= run_nxt[i];
				avail_r[i] <= avail_nxt[i];
			end
		end
	end

	// ****************************************************************
	// Counters, one of each kind per path
	// ****************************************************************
	for (genvar p = 0; p < NUM_PATHS; p++)
	begin : g_path
		for (genvar k = 0; k < NK; k++)
		begin : g_kind
			spm_event_ctr #(
				.W(CNT_W),
				.AW(B3_W)
			) u_ctr (
				.i_ref_clk(i_ref_clk),
				.i_srst(i_srst),
				.i_en(ev_en[p][k]),
				.i_amount(ev_amt[p][k]),
				.o_count(cnt[p][k])
			);
		end
	end

	// ****************************************************************
	// Read-out of the selected path
	// ****************************************************************
	logic [CNT_W-1:0] rd_nxt [NK];
	logic [CNT_W-1:0] rd_r [NK];
	logic [CNT_W:0] diff_nxt, diff_r;
	logic jv_r;
	always_comb
	begin
		logic signed [CNT_W+1:0] net;
		net = $signed({2'b00, cnt[i_rd_sel][K_PPG]}) - $signed({2'b00, cnt[i_rd_sel][K_NPG]})
			- $signed({2'b00, cnt[i_rd_sel][K_PPD]}) + $signed({2'b00, cnt[i_rd_sel][K_NPD]});
		// Saturated counts can push the magnitude one bit past the counter width
		diff_nxt = net[CNT_W+1] ? (CNT_W+1)'(-net) : net[CNT_W:0];
		for (int k = 0; k < NK; k++)
			rd_nxt[k] = cnt[i_rd_sel][k];
		if (!i_just_mon_enable)
		begin
			for (int k = K_PPD; k < NK; k++)
				rd_nxt[k] = '0;
			diff_nxt = '0;
		end
	end
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			for (int k = 0; k < NK; k++)
				rd_r[k] <= '0;
			diff_r <= '0;
			jv_r <= 1'b0;
		end
		else
		begin
			for (int k = 0; k < NK; k++)
				rd_r[k] <= rd_nxt[k];
			diff_r <= diff_nxt;
			jv_r <= i_just_mon_enable;
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_PATHS; i++)
			o_unavailable[i] = (avail_r[i] == SPM_UNAVAIL);
	end

	assign o_sec_tick = tick;
	assign o_gen_pos_just = gpos_r;
	assign o_gen_neg_just = gneg_r;
	assign o_ptr_fault = pfault_r;
	assign o_threshold_crossing_alert = tca_r;
	assign o_path_parity_violation_count = rd_r[K_CV];
	assign o_path_errored_seconds = rd_r[K_ES];
	assign o_path_severe_errored_seconds = rd_r[K_SES];
	assign o_path_unavailable_seconds = rd_r[K_UAS];
	assign o_path_failure_event_count = rd_r[K_FC];
	assign o_just_valid = jv_r;
	assign o_pos_just_detected_count = rd_r[K_PPD];
	assign o_neg_just_detected_count = rd_r[K_NPD];
	assign o_pos_just_generated_count = rd_r[K_PPG];
	assign o_neg_just_generated_count = rd_r[K_NPG];
	assign o_just_count_difference = diff_r;
	assign o_detected_just_seconds = rd_r[K_PJSD];
	assign o_generated_just_seconds = rd_r[K_PJSG];
endmodule

// ---- hdl/spm_pkg.sv ----
// Shared constants for the path performance monitor.
// Assumes a single 250 MHz card clock and framer event inputs on that clock.
package spm_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_FREQ_KHZ = 250000;
	localparam int ONE_SEC_MS = 1000;
	localparam int SEC_CYCLES_DFLT = ONE_SEC_MS * CLK_FREQ_KHZ;

	// ****************************************************************
	// Pointer and error limits
	// ****************************************************************
	localparam int PTR_W = 10;
	localparam logic [PTR_W-1:0] PTR_MIN = 10'h000;
	localparam logic [PTR_W-1:0] PTR_MAX = 10'h30e;
	localparam int B3_W = 4;
	localparam logic [B3_W-1:0] B3_MAX_PER_FRAME = 4'h8;
	localparam int SEC_W = 16;
	localparam logic [SEC_W-1:0] SES_CV_THRESH = 16'h0960;
	localparam int RUN_W = 4;
	localparam logic [RUN_W-1:0] UAS_RUN = 4'ha;
	localparam logic [RUN_W-1:0] RUN_RST = 4'h0;

	// ****************************************************************
	// Counter kinds, one counter of each kind per path
	// ****************************************************************
	localparam int K_CV = 0;
	localparam int K_ES = 1;
	localparam int K_SES = 2;
	localparam int K_UAS = 3;
	localparam int K_FC = 4;
	localparam int K_PPD = 5;
	localparam int K_NPD = 6;
	localparam int K_PPG = 7;
	localparam int K_NPG = 8;
	localparam int K_PJSD = 9;
	localparam int K_PJSG = 10;
	localparam int NK = 11;

	typedef enum logic {SPM_AVAIL, SPM_UNAVAIL} spm_avail_t;
endpackage

// ---- hdl/spm_sec_timer.sv ----
// Free-running one-second timebase.
// Assumes a synchronous active-high reset on the card clock.
`timescale 1ns/1ns
module spm_sec_timer #(
	parameter int SEC_CYCLES = spm_pkg::SEC_CYCLES_DFLT
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	output logic o_sec_tick
);
	import spm_pkg::*;
	localparam int TW = $clog2(SEC_CYCLES + 1);
	localparam logic [TW-1:0] LAST = TW'(SEC_CYCLES - 1);

	logic [TW-1:0] cnt_r;
	logic [TW-1:0] cnt_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb
	begin
		tick_nxt = (cnt_r == LAST);
		cnt_nxt = tick_nxt ? '0 : cnt_r + TW'(1);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_sec_tick = tick_r;
endmodule

// ---- hdl/spm_event_ctr.sv ----
// Saturating event counter that adds a small amount per enabled cycle.
// Assumes the caller gates the enable; it never wraps.
`timescale 1ns/1ns
module spm_event_ctr #(
	parameter int W = 16,
	parameter int AW = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_en,
	input wire logic [AW-1:0] i_amount,
	output logic [W-1:0] o_count
);
	import spm_pkg::*;
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [W:0] sum;

	always_comb
	begin
		sum = {1'b0, cnt_r} + (W+1)'(i_amount);
		cnt_nxt = cnt_r;
		if (i_en)
			cnt_nxt = sum[W] ? '1 : sum[W-1:0];
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign o_count = cnt_r;
endmodule

// ---- test/spm_framer_model.sv ----
// Framer model: one frame pulse per request, with its B3 error count.
// Assumes the bench raises a request for a single clock.
`timescale 1ns/1ns
module spm_framer_model (
	input wire logic i_ref_clk,
	input wire logic [1:0] i_go,
	input wire logic [3:0] i_b3,
	output logic [1:0] o_frame_pulse,
	output logic [7:0] o_b3_err_cnt
);
	initial o_frame_pulse = 2'h0;
	initial o_b3_err_cnt = 8'h00;
	// Count is inverted between frames so a stray sample cannot pass
	always @(posedge i_ref_clk)
	begin
		o_frame_pulse <= i_go;
		o_b3_err_cnt <= (i_go != 2'h0) ? {2{i_b3}} : ~o_b3_err_cnt;
	end
endmodule

// ---- test/spm_chk_monitor.sv ----
// Port checker for the path performance monitor.
// Assumes it is bound into every spm_monitor instance.
`timescale 1ns/1ns
module spm_chk #(
	parameter int NUM_PATHS = 4,
	parameter int CNT_W = 16,
	parameter int SEC_CYCLES = 100
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [NUM_PATHS-1:0] i_monitor_enable,
	input wire logic [NUM_PATHS-1:0] i_ccat_tail,
	input wire logic [NUM_PATHS-1:0] i_frame_pulse,
	input wire logic [NUM_PATHS-1:0] i_spe_slow,
	input wire logic [NUM_PATHS-1:0] i_spe_fast,
	input wire logic [NUM_PATHS-1:0] i_ptr_valid,
	input wire logic [$clog2(NUM_PATHS)-1:0] i_rd_sel,
	input wire logic o_sec_tick,
	input wire logic [NUM_PATHS-1:0] o_gen_pos_just,
	input wire logic [NUM_PATHS-1:0] o_gen_neg_just,
	input wire logic [NUM_PATHS-1:0] o_ptr_fault,
	input wire logic [NUM_PATHS-1:0] o_unavailable,
	input wire logic [NUM_PATHS-1:0] o_threshold_crossing_alert,
	input wire logic [CNT_W-1:0] o_path_parity_violation_count,
	input wire logic o_just_valid,
	input wire logic [CNT_W-1:0] o_pos_just_detected_count,
	input wire logic [CNT_W:0] o_just_count_difference
);
	// ********
	// Tick spacing
	// ********
	int gap_r;
	logic seen_r;
	always_ff @(posedge i_ref_clk)
	begin
		gap_r <= (i_srst || o_sec_tick) ? 0 : gap_r + 1;
		seen_r <= !i_srst && (seen_r || o_sec_tick);
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);
	// ********
	// Assertions
	// ********
	a_tick_period: assert property (o_sec_tick && seen_r |-> gap_r == SEC_CYCLES - 1)
		else $error("second tick spacing wrong");
	a_alert_tick: assert property (o_threshold_crossing_alert != 0 |-> $past(o_sec_tick))
		else $error("alert outside second close");
	a_alert_enabled: assert property (
		(o_threshold_crossing_alert & ~$past(i_monitor_enable & ~i_ccat_tail)) == 0)
		else $error("alert on unmonitored path");
	a_gen_pos_cause: assert property ((o_gen_pos_just & ~$past(i_frame_pulse & i_spe_slow)) == 0)
		else $error("positive justification without slow frame");
	a_gen_neg_cause: assert property (
		(o_gen_neg_just & ~$past(i_frame_pulse & i_spe_fast & ~i_spe_slow)) == 0)
		else $error("negative justification without fast frame");
	a_gen_exclusive: assert property ((o_gen_pos_just & o_gen_neg_just) == 0)
		else $error("both justifications at once");
	a_unavail_close: assert property (o_unavailable != $past(o_unavailable) |-> $past(o_sec_tick))
		else $error("availability changed off the second");
	a_fault_cause: assert property (o_ptr_fault != $past(o_ptr_fault) |-> $past(i_ptr_valid) != 0)
		else $error("pointer fault changed without pointer");
	a_cv_monotonic: assert property (i_rd_sel == $past(i_rd_sel) && i_rd_sel == $past(i_rd_sel, 2)
		|-> o_path_parity_violation_count >= $past(o_path_parity_violation_count))
		else $error("parity count went down");
	a_just_blank: assert property (!o_just_valid && !$past(o_just_valid)
		|-> o_pos_just_detected_count == 0 && o_just_count_difference == 0)
		else $error("justification count shown while disabled");
endmodule
bind spm_monitor spm_chk #(.NUM_PATHS(NUM_PATHS), .CNT_W(CNT_W), .SEC_CYCLES(SEC_CYCLES)) u_chk (
	.i_ref_clk, .i_srst, .i_monitor_enable, .i_ccat_tail, .i_frame_pulse, .i_spe_slow,
	.i_spe_fast, .i_ptr_valid, .i_rd_sel, .o_sec_tick, .o_gen_pos_just, .o_gen_neg_just,
	.o_ptr_fault, .o_unavailable, .o_threshold_crossing_alert, .o_path_parity_violation_count,
	.o_just_valid, .o_pos_just_detected_count, .o_just_count_difference
);

// ---- test/spm_monitor_test.sv ----
// Self-checking bench for the path performance monitor.
// Assumes a 100 cycle second so the unavailable run stays short.
`timescale 1ns/1ns
module spm_monitor_test;
	logic clk = 1'b0, srst = 1'b1, jen = 1'b0, sel = 1'b0, tick, jv;
	logic [1:0] en = 2'h0, tail = 2'h0, go = 2'h0, ais = 2'h0, lop = 2'h0, ptv = 2'h0;
	logic [1:0] pjp = 2'h0, pjn = 2'h0, slow = 2'h0, fast = 2'h0, fp, gp, gn, pf, un, threshold_crossing_alert;
	logic [1:0] ld = 2'h0, uq = 2'h0, tm = 2'h0;
	logic [3:0] b3 = 4'h0;
	logic [7:0] b3b;
	logic [15:0] thr = 16'hffff, cv, es, ses, uas, fc, ppd, npd, ppg, npg, pjsd, pjsg;
	logic [16:0] diff;
	logic [19:0] ptr = 20'h00000;
	int mismatches = 0, n_tests = 0;
	spm_monitor #(.NUM_PATHS(2), .CNT_W(16), .SEC_CYCLES(100)) DUT (
		.i_ref_clk(clk), .i_srst(srst), .i_monitor_enable(en), .i_ccat_tail(tail),
		.i_just_mon_enable(jen), .i_tca_cv_thresh(thr), .i_frame_pulse(fp),
		.i_b3_err_cnt(b3b), .i_ais(ais), .i_lop(lop), .i_lower_defect(ld),
		.i_uneq(uq), .i_tim(tm), .i_ptr_valid(ptv), .i_ptr_value(ptr),
		.i_pj_det_pos(pjp), .i_pj_det_neg(pjn), .i_spe_slow(slow), .i_spe_fast(fast),
		.i_rd_sel(sel), .o_sec_tick(tick), .o_gen_pos_just(gp), .o_gen_neg_just(gn),
		.o_ptr_fault(pf), .o_unavailable(un), .o_threshold_crossing_alert(threshold_crossing_alert),
		.o_path_parity_violation_count(cv), .o_path_errored_seconds(es),
		.o_path_severe_errored_seconds(ses), .o_path_unavailable_seconds(uas),
		.o_path_failure_event_count(fc), .o_just_valid(jv),
		.o_pos_just_detected_count(ppd), .o_neg_just_detected_count(npd),
		.o_pos_just_generated_count(ppg), .o_neg_just_generated_count(npg),
		.o_just_count_difference(diff), .o_detected_just_seconds(pjsd),
		.o_generated_just_seconds(pjsg)
	);
	spm_framer_model u_frm (.i_ref_clk(clk), .i_go(go), .i_b3(b3), .o_frame_pulse(fp),
		.o_b3_err_cnt(b3b));
	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Returns just after an edge, in the cycle where the tick stands
	task automatic wtick();
		for (int i = 0; i < 300; i++)
		begin
			@(posedge clk);
			#1;
			if (tick === 1'b1)
				break;
		end
		chk(tick, 1'b1, "tick");
	endtask
	task automatic rd(input logic s);
		@(posedge clk) sel <= s;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic frm(input logic [1:0] g, input logic [3:0] b);
		@(posedge clk) go <= g;
		b3 <= b;
		@(posedge clk) go <= 2'h0;
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_parity();
		@(posedge clk) en <= 2'h1;
		thr <= 16'h0005;
		wtick();
		frm(2'h3, 4'h3);
		frm(2'h3, 4'hf);
		wtick();
		@(posedge clk) #1;
		chk(threshold_crossing_alert, 2'h1, "alert");
		rd(1'b0);
		chk(cv, 16'd11, "parity path0");
		chk(es, 16'd1, "errored s");
		chk(ses, 16'd0, "severe s");
		rd(1'b1);
		chk(cv, 16'd0, "parity path1");
		$display("test parity done");
	endtask
	task automatic t_group();
		@(posedge clk) en <= 2'h3;
		tail <= 2'h2;
		frm(2'h3, 4'h2);
		rd(1'b1);
		chk(cv, 16'd0, "tail path");
		@(posedge clk) tail <= 2'h0;
		frm(2'h2, 4'h1);
		rd(1'b1);
		chk(cv, 16'd1, "member path");
		$display("test group done");
	endtask
	task automatic t_just();
		@(posedge clk) pjp <= 2'h1;
		@(posedge clk) pjp <= 2'h0;
		rd(1'b0);
		chk(ppd, 16'd0, "blank count");
		chk(jv, 1'b0, "just valid");
		@(posedge clk) jen <= 1'b1;
		wtick();
		@(posedge clk) pjp <= 2'h1;
		repeat (3) @(posedge clk);
		pjp <= 2'h0;
		pjn <= 2'h1;
		@(posedge clk) pjn <= 2'h0;
		slow <= 2'h1;
		frm(2'h1, 4'h0);
		@(posedge clk) slow <= 2'h0;
		fast <= 2'h1;
		#1;
		chk(gp, 2'h1, "gen pos pulse");
		frm(2'h1, 4'h0);
		@(posedge clk) fast <= 2'h0;
		#1;
		chk(gn, 2'h1, "gen neg pulse");
		rd(1'b0);
		chk(ppd, 16'd3, "pos det");
		chk(npd, 16'd1, "neg det");
		chk(ppg, 16'd1, "pos gen");
		chk(npg, 16'd1, "neg gen");
		chk(diff, 17'd2, "difference");
		wtick();
		rd(1'b0);
		chk(pjsd, 16'd1, "det seconds");
		chk(pjsg, 16'd1, "gen seconds");
		chk(jv, 1'b1, "just valid on");
		@(posedge clk) jen <= 1'b0;
		rd(1'b0);
		chk(ppd, 16'd0, "pos det blanked");
		chk(diff, 17'd0, "difference blanked");
		$display("test justification done");
	endtask
	task automatic t_fail_ptr();
		wtick();
		@(posedge clk) ais <= 2'h1;
		@(posedge clk) ais <= 2'h0;
		repeat (3) @(posedge clk);
		lop <= 2'h1;
		@(posedge clk) lop <= 2'h0;
		// Unequipped then mismatch back to back is one unbroken failure event
		@(posedge clk) uq <= 2'h1;
		@(posedge clk) uq <= 2'h0;
		tm <= 2'h1;
		@(posedge clk) tm <= 2'h0;
		rd(1'b0);
		chk(fc, 16'd3, "failures");
		@(posedge clk) ptr <= {2{10'h30f}};
		ptv <= 2'h1;
		@(posedge clk) ptv <= 2'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(pf, 2'h1, "fault 783");
		@(posedge clk) ptr <= {2{10'h30e}};
		ptv <= 2'h1;
		@(posedge clk) ptv <= 2'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(pf, 2'h0, "fault 782");
		@(posedge clk) ld <= 2'h2;
		@(posedge clk) ld <= 2'h0;
		wtick();
		rd(1'b1);
		chk(es, 16'd2, "lower defect errored s");
		chk(ses, 16'd0, "lower defect not severe");
		$display("test failure and pointer done");
	endtask
	task automatic t_unavail();
		wtick();
		wtick();
		@(posedge clk) ais <= 2'h1;
		repeat (9) wtick();
		@(posedge clk) #1;
		chk(un, 2'h0, "nine severe");
		wtick();
		@(posedge clk) ais <= 2'h0;
		#1;
		chk(un, 2'h1, "ten severe");
		repeat (9) wtick();
		@(posedge clk) #1;
		chk(un, 2'h1, "nine clean");
		wtick();
		@(posedge clk) #1;
		chk(un, 2'h0, "ten clean");
		rd(1'b0);
		chk(uas, 16'd10, "unavail s");
		chk(ses, 16'd11, "severe total");
		$display("test unavailable done");
	endtask
	// ********
	// Run
	// ********
	initial
	begin
		forever #2 clk = ~clk;
	end
	initial
	begin
		#60000;
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_parity();
		t_group();
		t_just();
		t_fail_ptr();
		t_unavail();
		give_verdict();
	end
endmodule
